// File: design/tcu_pkg.sv
// Package with register map, field layouts, reset values and modes of the timer/counter unit
package tcu_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_PERIOD = 8'h0c;
  localparam logic [7:0] ADDR_CC0 = 8'h10;
  localparam logic [7:0] ADDR_CC1 = 8'h14;
  localparam logic [7:0] ADDR_INTFLAG = 8'h18;
  localparam logic [7:0] ADDR_INTMASK = 8'h1c;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_WAVE_LSB = 3;
  localparam int CTRL_DOWN = 5;
  localparam int CTRL_EVCOUNT = 6;
  localparam int CTRL_PRESC_LSB = 7;
  localparam int CTRL_CAPEN_LSB = 10;
  localparam int CTRL_CAPEV = 12;
  localparam int CTRL_CAPEDGE_LSB = 13;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Counter width modes
  localparam logic [1:0] MODE_16 = 2'h0;
  localparam logic [1:0] MODE_8 = 2'h1;
  localparam logic [1:0] MODE_32 = 2'h2;

  // Waveform select field
  localparam logic [1:0] WAVE_NORMAL_FREQ = 2'h0;
  localparam logic [1:0] WAVE_MATCH_FREQ = 2'h1;
  localparam logic [1:0] WAVE_NORMAL_PWM = 2'h2;
  localparam logic [1:0] WAVE_MATCH_PWM = 2'h3;

  // Capture edge select
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // Interrupt flag bits
  localparam int IRQ_OVF = 0;
  localparam int IRQ_MC0 = 1;
  localparam int IRQ_MC1 = 2;
  localparam int IRQ_W = 3;

  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [31:0] MAX8 = 32'h0000_00ff;
  localparam logic [31:0] MAX16 = 32'h0000_ffff;
  localparam logic [31:0] MAX32 = 32'hffff_ffff;

  // Prescaler divider width
  localparam int PRESC_W = 10;

endpackage

// File: design/tcu_prescaler.sv
// Prescaler producing one-cycle count ticks from the generic timer clock enable
`timescale 1ns/1ps
module tcu_prescaler (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [2:0] sel,
  input wire logic clk_tick,
  // Output
  output logic tick
);

  logic [tcu_pkg::PRESC_W-1:0] div_q;
  logic [tcu_pkg::PRESC_W-1:0] div_d;
  logic [tcu_pkg::PRESC_W-1:0] lim;
  logic wrap;

  // ==========================================================================
  // Divide by 1, 2, 4, 8, 16, 64, 256 or 1024
  // ==========================================================================
  assign lim = (sel == 3'h0) ? 10'h000 :
               (sel == 3'h1) ? 10'h001 :
               (sel == 3'h2) ? 10'h003 :
               (sel == 3'h3) ? 10'h007 :
               (sel == 3'h4) ? 10'h00f :
               (sel == 3'h5) ? 10'h03f :
               (sel == 3'h6) ? 10'h0ff : 10'h3ff;
  assign wrap = (div_q >= lim);
  assign div_d = !run ? '0 : !clk_tick ? div_q : wrap ? '0 : div_q + 10'h001;
  assign tick = run && clk_tick && wrap;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

endmodule

// File: design/tcu_core.sv
// Timer/counter unit with counter, period, compare/capture channels and waveforms
`timescale 1ns/1ps
module tcu_core (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Clock, event and capture pin inputs
  input wire logic generic_timer_clock,
  input wire logic evt_in,
  input wire logic [1:0] cap_pin,
  // Event and DMA outputs
  output logic evt_ovf,
  output logic [1:0] evt_mc,
  output logic dma_req,
  // Waveform outputs
  output logic [1:0] wave_out,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Registers and wires
  // ==========================================================================
  logic [31:0] ctrl_q;
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic [7:0] period_value_q;
  logic [31:0] cc_q [2];
  logic [3:0] flag_q;
  logic [3:0] flag_d;
  logic [3:0] mask_q;
  logic [1:0] wave_q;
  logic evt_ovf_q;
  logic [1:0] evt_mc_q;
  logic dma_req_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic gclk_s1_q;
  logic gclk_s2_q;
  logic gclk_s3_q;
  logic evt_s1_q;
  logic evt_s2_q;
  logic evt_s3_q;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;

  wire enable = ctrl_q[tcu_pkg::CTRL_ENABLE];
  wire [1:0] mode = ctrl_q[tcu_pkg::CTRL_MODE_LSB +: 2];
  wire [1:0] waveform_select_field = ctrl_q[tcu_pkg::CTRL_WAVE_LSB +: 2];
  wire down = ctrl_q[tcu_pkg::CTRL_DOWN];
  wire ev_count = ctrl_q[tcu_pkg::CTRL_EVCOUNT];
  wire [2:0] presc_sel = ctrl_q[tcu_pkg::CTRL_PRESC_LSB +: 3];
  wire [1:0] cap_en = ctrl_q[tcu_pkg::CTRL_CAPEN_LSB +: 2];
  wire cap_from_event = ctrl_q[tcu_pkg::CTRL_CAPEV];
  wire [1:0] cap_edge = ctrl_q[tcu_pkg::CTRL_CAPEDGE_LSB +: 2];

  // ==========================================================================
  // Input synchronisers and edge detection
  // ==========================================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gclk_s1_q <= 1'b0;
      gclk_s2_q <= 1'b0;
      gclk_s3_q <= 1'b0;
      evt_s1_q <= 1'b0;
      evt_s2_q <= 1'b0;
      evt_s3_q <= 1'b0;
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
    end else begin
      gclk_s1_q <= generic_timer_clock;
      gclk_s2_q <= gclk_s1_q;
      gclk_s3_q <= gclk_s2_q;
      evt_s1_q <= evt_in;
      evt_s2_q <= evt_s1_q;
      evt_s3_q <= evt_s2_q;
      pin_s1_q <= cap_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  wire gclk_rise = gclk_s2_q && !gclk_s3_q;
  wire evt_rise = evt_s2_q && !evt_s3_q;
  wire [1:0] pin_rise = pin_s2_q & ~pin_s3_q;
  wire [1:0] pin_fall = ~pin_s2_q & pin_s3_q;

  // ==========================================================================
  // Count source
  // ==========================================================================
  logic presc_tick;

  tcu_prescaler u_presc (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(enable && !ev_count),
    .sel(presc_sel),
    .clk_tick(gclk_rise),
    .tick(presc_tick)
  );

  wire step = enable && (ev_count ? evt_rise : presc_tick);

  // ==========================================================================
  // Width, limits and next count
  // ==========================================================================
  function automatic logic [31:0] width_max(input logic [1:0] m);
    if (m == tcu_pkg::MODE_8) begin
      width_max = tcu_pkg::MAX8;
    end else if (m == tcu_pkg::MODE_32) begin
      width_max = tcu_pkg::MAX32;
    end else begin
      width_max = tcu_pkg::MAX16;
    end
  endfunction

  function automatic logic [31:0] trim(input logic [31:0] v, input logic [1:0] m);
    trim = v & width_max(m);
  endfunction

  wire [31:0] max_val = width_max(mode);
  wire cc0_is_top = (waveform_select_field == tcu_pkg::WAVE_MATCH_FREQ) ||
                    (waveform_select_field == tcu_pkg::WAVE_MATCH_PWM);
  wire [31:0] cc0_val = trim(cc_q[0], mode);
  wire [31:0] cc1_val = trim(cc_q[1], mode);
  wire [31:0] top_val = cc0_is_top ? cc0_val :
                        (mode == tcu_pkg::MODE_8) ? {24'h0, period_value_q} :
                        max_val;
  wire at_top = (count_q == top_val);
  wire at_zero = (count_q == 32'h0);
  wire limit_hit = step && (down ? at_zero : at_top);

  wire [31:0] count_up = at_top ? 32'h0 : trim(count_q + 32'h1, mode);
  wire [31:0] count_down = at_zero ? top_val : trim(count_q - 32'h1, mode);

  assign count_d = !step ? count_q : down ? count_down : count_up;

  // ==========================================================================
  // Compare and capture
  // ==========================================================================
  wire [1:0] match;
  wire [1:0] cap_trig;
  wire [1:0] pin_edge;

  assign match[0] = !cap_en[0] && step && (count_d == cc0_val);
  assign match[1] = !cap_en[1] && step && (count_d == cc1_val);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cap
      assign pin_edge[gi] = (cap_edge == tcu_pkg::EDGE_RISE) ? pin_rise[gi] :
                            (cap_edge == tcu_pkg::EDGE_FALL) ? pin_fall[gi] :
                            (cap_edge == tcu_pkg::EDGE_BOTH) ? (pin_rise[gi] | pin_fall[gi]) : 1'b0;
      assign cap_trig[gi] = enable && cap_en[gi] && (cap_from_event ? evt_rise : pin_edge[gi]);
    end
  endgenerate

  // ==========================================================================
  // Register decode
  // ==========================================================================
  // Address hits shared by the write strobes and the read mux
  wire hit_ctrl = (reg_addr == tcu_pkg::ADDR_CTRL);
  wire hit_status = (reg_addr == tcu_pkg::ADDR_STATUS);
  wire hit_count = (reg_addr == tcu_pkg::ADDR_COUNT);
  wire hit_period = (reg_addr == tcu_pkg::ADDR_PERIOD);
  wire hit_cc0 = (reg_addr == tcu_pkg::ADDR_CC0);
  wire hit_cc1 = (reg_addr == tcu_pkg::ADDR_CC1);
  wire hit_flag = (reg_addr == tcu_pkg::ADDR_INTFLAG);
  wire hit_mask = (reg_addr == tcu_pkg::ADDR_INTMASK);

  wire wr_ctrl = reg_wr && hit_ctrl;
  wire wr_count = reg_wr && hit_count;
  wire wr_period = reg_wr && hit_period;
  wire wr_cc0 = reg_wr && hit_cc0;
  wire wr_cc1 = reg_wr && hit_cc1;
  wire wr_flag = reg_wr && hit_flag;
  wire wr_mask = reg_wr && hit_mask;

  wire [31:0] status_word = {28'h0, wave_q, enable, down};

  assign rdata_d = !reg_rd ? 32'h0 :
                   hit_ctrl ? ctrl_q :
                   hit_status ? status_word :
                   hit_count ? count_q :
                   hit_period ? {24'h0, period_value_q} :
                   hit_cc0 ? cc_q[0] :
                   hit_cc1 ? cc_q[1] :
                   hit_flag ? {28'h0, flag_q} :
                   hit_mask ? {28'h0, mask_q} : 32'h0;

  // Hardware set wins over a write-one clear in the same cycle
  wire [3:0] flag_set;
  assign flag_set[tcu_pkg::IRQ_OVF] = limit_hit;
  assign flag_set[tcu_pkg::IRQ_MC0] = match[0];
  assign flag_set[tcu_pkg::IRQ_MC1] = match[1];
  assign flag_set[tcu_pkg::IRQ_W] = 1'b0;
  assign flag_d = (flag_q & ~(wr_flag ? reg_wdata[3:0] : 4'h0)) | flag_set;

  // ==========================================================================
  // Event, DMA and interrupt sources
  // ==========================================================================
  wire ovf_pulse_d = limit_hit;
  wire [1:0] mc_pulse_d = match | cap_trig;
  wire dma_pulse_d = limit_hit | (|match);
  wire irq_level = |(flag_q & mask_q);

  // ==========================================================================
  // Waveform generation
  // ==========================================================================
  wire is_pwm = (waveform_select_field == tcu_pkg::WAVE_NORMAL_PWM) ||
                (waveform_select_field == tcu_pkg::WAVE_MATCH_PWM);
  logic [1:0] wave_d;

  always_comb begin
    wave_d = wave_q;
    if (!enable) begin
      wave_d = 2'h0;
    end else if (is_pwm) begin
      // Output high from the limit until the channel compare match; channel zero held low in match PWM
      wave_d[0] = (waveform_select_field == tcu_pkg::WAVE_MATCH_PWM) ? 1'b0 :
                  (down ? (count_d > cc0_val) : (count_d < cc0_val));
      wave_d[1] = down ? (count_d > cc1_val) : (count_d < cc1_val);
    end else begin
      // Frequency modes toggle on each channel match, channel zero on the limit in match frequency
      wave_d[0] = wave_q[0] ^ (cc0_is_top ? limit_hit : match[0]);
      wave_d[1] = wave_q[1] ^ match[1];
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= tcu_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      period_value_q <= tcu_pkg::PERIOD_RESET;
    end else if (wr_period) begin
      period_value_q <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_q <= 4'h0;
    end else if (wr_mask) begin
      mask_q <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_q <= 4'h0;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_q <= 32'h0;
    end else if (wr_count) begin
      count_q <= trim(reg_wdata, mode);
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cc_q[0] <= 32'h0;
      cc_q[1] <= 32'h0;
    end else begin
      if (cap_trig[0]) begin
        cc_q[0] <= count_q;
      end else if (wr_cc0) begin
        cc_q[0] <= trim(reg_wdata, mode);
      end
      if (cap_trig[1]) begin
        cc_q[1] <= count_q;
      end else if (wr_cc1) begin
        cc_q[1] <= trim(reg_wdata, mode);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wave_q <= 2'h0;
      rdata_q <= 32'h0;
    end else begin
      wave_q <= wave_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evt_ovf_q <= 1'b0;
      evt_mc_q <= 2'h0;
      dma_req_q <= 1'b0;
    end else begin
      evt_ovf_q <= ovf_pulse_d;
      evt_mc_q <= mc_pulse_d;
      dma_req_q <= dma_pulse_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign reg_rdata = rdata_q;
  assign evt_ovf = evt_ovf_q;
  assign evt_mc = evt_mc_q;
  assign dma_req = dma_req_q;
  assign wave_out = wave_q;
  assign irq = irq_level;

endmodule

// File: dv/tcu_far_model.sv
// Model of the event system and I/O pins driving the timer/counter unit
`timescale 1ns/1ps
module tcu_far_model (
  // Clock
  input wire logic sys_clk,
  // Commands from the bench
  input wire logic clk_run,
  input wire logic evt_req,
  input wire logic [1:0] pin_req,
  // Far-side outputs
  output logic generic_timer_clock,
  output logic evt_in,
  output logic [1:0] cap_pin
);
  logic [2:0] div_q;
  logic [2:0] evt_q;
  // Timer clock at one eighth of sys_clk, held low between bursts
  always_ff @(posedge sys_clk) begin
    div_q <= clk_run ? div_q + 3'h1 : 3'h0;
    evt_q <= evt_req ? 3'h4 : (evt_q != 3'h0 ? evt_q - 3'h1 : 3'h0);
    cap_pin <= pin_req;
  end
  assign generic_timer_clock = div_q[2];
  assign evt_in = (evt_q != 3'h0);
  initial begin
    div_q = 3'h0;
    evt_q = 3'h0;
    cap_pin = 2'h0;
  end
endmodule

// File: dv/tcu_core_properties.sv
// Checker of the timer/counter unit port behaviour
`timescale 1ns/1ps
module tcu_core_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Outputs
  input wire logic evt_ovf,
  input wire logic [1:0] evt_mc,
  input wire logic dma_req,
  input wire logic irq
);
  logic [14:0] ctrl_q;
  logic [3:0] dis_q;
  // ==========================================================================
  // Shadow of control and time spent disabled
  // ==========================================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= 15'h0;
      dis_q <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == tcu_pkg::ADDR_CTRL) ctrl_q <= reg_wdata[14:0];
      dis_q <= ctrl_q[0] ? 4'h0 : (dis_q != 4'hf ? dis_q + 4'h1 : dis_q);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  a_unmapped_read: assert property ($past(reg_rd) && $past(reg_addr) > 8'h1c |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property ($past(reg_rd) && $past(reg_addr) == tcu_pkg::ADDR_CTRL |->
    reg_rdata[14:0] == $past(ctrl_q)) else $error("control readback differs");
  a_limit_pulse: assert property (evt_ovf |=> !evt_ovf)
    else $error("limit pulse longer than one cycle");
  a_limit_dma: assert property (evt_ovf |-> dma_req)
    else $error("limit without dma request");
  a_match_pulse: assert property (evt_mc != 2'h0 |=> evt_mc == 2'h0)
    else $error("match pulse longer than one cycle");
  a_disabled_quiet: assert property (dis_q == 4'hf |-> !evt_ovf && !dma_req)
    else $error("activity while disabled");
  a_irq_rise_cause: assert property ($rose(irq) |-> evt_ovf || evt_mc != 2'h0 || $past(reg_wr))
    else $error("interrupt rose without cause");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(reg_wr))
    else $error("interrupt fell without write");
  c_limit: cover property (evt_ovf);
  c_match1: cover property (evt_mc[1]);
  c_irq: cover property ($rose(irq));
endmodule
bind tcu_core tcu_core_checker u_chk (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .evt_ovf, .evt_mc, .dma_req, .irq);

// File: dv/timer_counter_core_test.sv
// Self-checking testbench of the timer/counter unit
`timescale 1ns/1ps
module timer_counter_core_test;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r0; logic [31:0] r1;} tcu_row_s;
  logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, clk_run = 1'b0, evt_req = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  logic [1:0] pin_req = 2'h0, cap_pin, evt_mc, wave_out;
  logic generic_timer_clock, evt_in, evt_ovf, dma_req, irq;
  int num_errors = 0, n_checks = 0, ovf_n = 0, mc1_n = 0, dma_n = 0, cyc = 0;
  tcu_row_s rows[7] = '{'{tcu_pkg::ADDR_CTRL, 32'h0, 32'h0, 32'h0}, '{tcu_pkg::ADDR_PERIOD, 32'h42, 32'hff, 32'h42},
    '{tcu_pkg::ADDR_CC0, 32'h1234, 32'h0, 32'h1234}, '{tcu_pkg::ADDR_CC1, 32'hbeef, 32'h0, 32'hbeef},
    '{tcu_pkg::ADDR_INTMASK, 32'h7, 32'h0, 32'h7}, '{tcu_pkg::ADDR_COUNT, 32'h9, 32'h0, 32'h9},
    '{8'h20, 32'h5a, 32'h0, 32'h0}};
  always #10 sys_clk = ~sys_clk;
  tcu_core dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .generic_timer_clock(generic_timer_clock), .evt_in(evt_in),
    .cap_pin(cap_pin), .evt_ovf(evt_ovf), .evt_mc(evt_mc), .dma_req(dma_req), .wave_out(wave_out), .irq(irq));
  tcu_far_model far (.sys_clk(sys_clk), .clk_run(clk_run), .evt_req(evt_req), .pin_req(pin_req),
    .generic_timer_clock(generic_timer_clock), .evt_in(evt_in), .cap_pin(cap_pin));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task end_sim;
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask
  task fire;
    evt_req <= 1'b1;
    @(posedge sys_clk);
    evt_req <= 1'b0;
    repeat (12) @(posedge sys_clk);
  endtask
  task run_clk(input int n);
    clk_run <= 1'b1;
    repeat (n) @(posedge sys_clk);
    clk_run <= 1'b0;
    repeat (10) @(posedge sys_clk);
  endtask
  function automatic logic [31:0] ctl(logic [1:0] m, logic [1:0] w, logic dn, logic ev);
    logic [31:0] c;
    c = 32'h1;
    c[tcu_pkg::CTRL_MODE_LSB +: 2] = m;
    c[tcu_pkg::CTRL_WAVE_LSB +: 2] = w;
    c[tcu_pkg::CTRL_DOWN] = dn;
    c[tcu_pkg::CTRL_EVCOUNT] = ev;
    return c;
  endfunction
  always @(posedge sys_clk) begin
    cyc++;
    if (evt_ovf === 1'b1) ovf_n++;
    if (evt_mc[1] === 1'b1) mc1_n++;
    if (dma_req === 1'b1) dma_n++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim;
    end
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      rdchk(rows[i].a, rows[i].r0);
      wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].r1);
    end
    // 8-bit mode bounded by period, interrupt masking and clearing
    wr(tcu_pkg::ADDR_PERIOD, 32'h3);
    wr(tcu_pkg::ADDR_COUNT, 32'h0);
    wr(tcu_pkg::ADDR_CTRL, ctl(tcu_pkg::MODE_8, tcu_pkg::WAVE_NORMAL_FREQ, 1'b0, 1'b1));
    for (int i = 1; i <= 4; i++) begin
      fire;
      rdchk(tcu_pkg::ADDR_COUNT, 32'(i % 4));
    end
    chk(32'(ovf_n), 32'h1);
    rdchk(tcu_pkg::ADDR_INTFLAG, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(tcu_pkg::ADDR_INTMASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(tcu_pkg::ADDR_INTMASK, 32'h7);
    wr(tcu_pkg::ADDR_INTFLAG, 32'h1);
    chk({31'h0, irq}, 32'h0);
    // Down counting wraps from zero to the 16-bit maximum
    wr(tcu_pkg::ADDR_CTRL, 32'h0);
    wr(tcu_pkg::ADDR_COUNT, 32'h0);
    wr(tcu_pkg::ADDR_CTRL, ctl(tcu_pkg::MODE_16, tcu_pkg::WAVE_NORMAL_FREQ, 1'b1, 1'b1));
    fire;
    rdchk(tcu_pkg::ADDR_COUNT, 32'hffff);
    fire;
    rdchk(tcu_pkg::ADDR_COUNT, 32'hfffe);
    chk(32'(ovf_n), 32'h2);
    // 32-bit up wrap
    wr(tcu_pkg::ADDR_CTRL, ctl(tcu_pkg::MODE_32, tcu_pkg::WAVE_NORMAL_FREQ, 1'b0, 1'b1));
    wr(tcu_pkg::ADDR_COUNT, 32'hffff_ffff);
    fire;
    rdchk(tcu_pkg::ADDR_COUNT, 32'h0);
    chk(32'(ovf_n), 32'h3);
    // Match frequency: channel zero is the period, channel one matches
    wr(tcu_pkg::ADDR_CTRL, 32'h0);
    wr(tcu_pkg::ADDR_CC0, 32'h2);
    wr(tcu_pkg::ADDR_CC1, 32'h1);
    wr(tcu_pkg::ADDR_COUNT, 32'h0);
    wr(tcu_pkg::ADDR_INTFLAG, 32'h7);
    wr(tcu_pkg::ADDR_CTRL, ctl(tcu_pkg::MODE_16, tcu_pkg::WAVE_MATCH_FREQ, 1'b0, 1'b1));
    chk({30'h0, wave_out}, 32'h0);
    repeat (3) fire;
    rdchk(tcu_pkg::ADDR_COUNT, 32'h0);
    chk(32'(mc1_n), 32'h1);
    chk(32'(dma_n), 32'h6);
    chk({30'h0, wave_out}, 32'h3);
    rd(tcu_pkg::ADDR_INTFLAG, v);
    chk(v & 32'h5, 32'h5);
    // Normal PWM: each output high while the count is below its channel value
    wr(tcu_pkg::ADDR_CTRL, 32'h0);
    wr(tcu_pkg::ADDR_COUNT, 32'h0);
    wr(tcu_pkg::ADDR_CTRL, ctl(tcu_pkg::MODE_16, tcu_pkg::WAVE_NORMAL_PWM, 1'b0, 1'b1));
    @(posedge sys_clk);
    chk({30'h0, wave_out}, 32'h3);
    fire;
    chk({30'h0, wave_out}, 32'h1);
    fire;
    chk({30'h0, wave_out}, 32'h0);
    // Match PWM: channel zero bounds the count, channel one sets the pulse width
    wr(tcu_pkg::ADDR_CTRL, ctl(tcu_pkg::MODE_16, tcu_pkg::WAVE_MATCH_PWM, 1'b0, 1'b1));
    fire;
    rdchk(tcu_pkg::ADDR_COUNT, 32'h0);
    chk({30'h0, wave_out}, 32'h2);
    // Generic timer clock, undivided then divided by four
    wr(tcu_pkg::ADDR_CTRL, 32'h0);
    wr(tcu_pkg::ADDR_COUNT, 32'h0);
    wr(tcu_pkg::ADDR_CTRL, ctl(tcu_pkg::MODE_16, tcu_pkg::WAVE_NORMAL_FREQ, 1'b0, 1'b0));
    run_clk(40);
    rdchk(tcu_pkg::ADDR_COUNT, 32'h5);
    wr(tcu_pkg::ADDR_CTRL, 32'h0);
    wr(tcu_pkg::ADDR_COUNT, 32'h0);
    wr(tcu_pkg::ADDR_CTRL, ctl(tcu_pkg::MODE_16, tcu_pkg::WAVE_NORMAL_FREQ, 1'b0, 1'b0) | 32'h100);
    run_clk(64);
    rdchk(tcu_pkg::ADDR_COUNT, 32'h2);
    // Capture from a pin edge, then from an event
    wr(tcu_pkg::ADDR_CTRL, 32'h0);
    wr(tcu_pkg::ADDR_COUNT, 32'h55);
    wr(tcu_pkg::ADDR_CTRL, ctl(tcu_pkg::MODE_16, tcu_pkg::WAVE_NORMAL_FREQ, 1'b0, 1'b0) | 32'h400);
    pin_req <= 2'h1;
    repeat (10) @(posedge sys_clk);
    rdchk(tcu_pkg::ADDR_CC0, 32'h55);
    wr(tcu_pkg::ADDR_COUNT, 32'h66);
    wr(tcu_pkg::ADDR_CTRL, ctl(tcu_pkg::MODE_16, tcu_pkg::WAVE_NORMAL_FREQ, 1'b0, 1'b0) | 32'h1800);
    fire;
    rdchk(tcu_pkg::ADDR_CC1, 32'h66);
    wr(tcu_pkg::ADDR_COUNT, 32'h77);
    wr(tcu_pkg::ADDR_CTRL, ctl(tcu_pkg::MODE_16, tcu_pkg::WAVE_NORMAL_FREQ, 1'b0, 1'b0) | 32'h2400);
    pin_req <= 2'h0;
    repeat (10) @(posedge sys_clk);
    rdchk(tcu_pkg::ADDR_CC0, 32'h77);
    // Reset in mid-run returns the registers to their reset values
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdchk(tcu_pkg::ADDR_CTRL, 32'h0);
    rdchk(tcu_pkg::ADDR_PERIOD, 32'hff);
    wr(tcu_pkg::ADDR_COUNT, 32'h12345);
    rdchk(tcu_pkg::ADDR_COUNT, 32'h2345);
    end_sim;
  end
endmodule
